/* File: include/hpm_pkg.sv */
// Shared types and constants of the harvester power mode sequencer.
// Assumes a single 100 MHz clock; levels are coded in units of 10 mV.
package hpm_pkg;

	// Clock rate and timing figures
	localparam int CLK_MHZ = 100;
	localparam int GRACE_TIME_US = 600000;
	localparam int MPPT_SAMPLE_TIME_US = 5120;
	localparam int MPPT_PERIOD_TIME_US = 330000;
	localparam int GRACE_CYCLES = GRACE_TIME_US * CLK_MHZ;
	localparam int MPPT_SAMPLE_CYCLES = MPPT_SAMPLE_TIME_US * CLK_MHZ;
	localparam int MPPT_PERIOD_CYCLES = MPPT_PERIOD_TIME_US * CLK_MHZ;
	localparam int TIMER_W = 26;

	// Regulator levels, 10 mV units
	localparam logic [8:0] LEVEL_1V2 = 9'h078;
	localparam logic [8:0] LEVEL_1V8 = 9'h0B4;
	localparam logic [8:0] LEVEL_2V5 = 9'h0FA;
	localparam logic [8:0] LEVEL_3V3 = 9'h14A;

	// Register map, byte addresses
	localparam logic [7:0] CTRL_OFFSET = 8'h00;
	localparam logic [7:0] STATUS_OFFSET = 8'h04;
	localparam logic [8:0] CTRL_CUSTOM_HV_RESET = 9'h0DC;
	localparam int CTRL_CUSTOM_HV_LSB = 0;
	localparam int STATUS_MODE_LSB = 0;
	localparam int STATUS_LDO_READY_BIT = 3;
	localparam int STATUS_LOW_ENERGY_BIT = 4;
	localparam int STATUS_MPPT_BUSY_BIT = 5;
	localparam int STATUS_COLD_STORAGE_BIT = 6;

	// Bus responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_DECERR = 2'h3;

	// Operating modes
	typedef enum logic [2:0] {
		DEEP_SLEEP,
		WAKE_RISE,
		WAKE_BOOST,
		WAKE_CHARGE,
		NORMAL,
		OVERVOLTAGE,
		PRIMARY,
		SHUTDOWN
	} hpm_mode_e;

	// Threshold comparator results
	typedef struct packed {
		logic sourceColdOk;
		logic storageColdOk;
		logic boostAtBuckLevel;
		logic boostAtFullCharge;
		logic storageAboveChargeReady;
		logic storageAboveFullCharge;
		logic storageBelowDepletion;
		logic backupCellCharged;
	} hpm_comp_s;

	// Whole state of the sequencer
	typedef struct packed {
		hpm_mode_e mode;
		logic strapTaken;
		logic coldFromStorage;
		logic [TIMER_W-1:0] graceCount;
		logic [TIMER_W-1:0] periodCount;
		logic ldoReady;
		logic lowEnergy;
		logic mpptBusy;
		logic sourceSwitch;
		logic linkSwitch;
		logic backupSwitch;
		logic boostEnable;
		logic buckEnable;
		logic lowRailOn;
		logic highRailOn;
		logic [8:0] lowRailLevel;
		logic [8:0] highRailLevel;
		logic [8:0] customHighRail;
		logic awHeld;
		logic wHeld;
		logic [7:0] awAddr;
		logic [31:0] wData;
		logic [3:0] wStrb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
	} hpm_state_s;

endpackage

/* File: logic/hpm_sync.sv */
// Two-stage synchroniser for a bundle of comparator levels.
// Assumes each bit is a slow level; bits are not coherent with each other.
`timescale 1ns/1ns
module hpm_sync #(
	parameter int WIDTH = 8
) (
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic [WIDTH-1:0] asyncIn,
	output logic [WIDTH-1:0] syncOut
);
	typedef struct packed {
		logic [WIDTH-1:0] first;
		logic [WIDTH-1:0] second;
	} hpm_sync_s;

	hpm_sync_s s;
	hpm_sync_s next_s;

	// Shift through both stages; only the second is read
	always_comb
	begin
		next_s.first = asyncIn;
		next_s.second = s.first;
	end

	// State register
	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
			s <= '0;
		else
			s <= next_s;
	end

	assign syncOut = s.second;
endmodule

/* File: logic/hpm_sequencer.sv */
// Power mode sequencer of the harvesting power manager with AXI4-Lite registers.
// Assumes comparator inputs are asynchronous levels; pins and bus are synchronous.
// Summary of operation
// - Cold-start conditions move deep sleep to wake up.
// - Wake up keeps regulators off, ready flag low.
// - Boost and buck rise first, then boost to full charge with buck kept on.
// - Charge to ready level, then normal, flag raised.
// - Storage already charged goes straight to normal.
// - Normal holds between depletion and full charge.
// - Above full charge moves normal to overvoltage.
// - Depletion enters primary with backup, else shutdown.
// - Storage link closed throughout normal mode.
// - Storage link opens on depletion into shutdown, stays closed in primary.
// - Primary closes backup switch, opens source switch.
// - Source switch opens periodically for tracking samples.
// - Each regulator follows its own enable pin.
// - High rail from profile, custom up to limit.
// - Low rail is one of two profile levels.
// - Grace time in shutdown between low-energy flag and deep sleep.
// - Strap selects storage or harvester cold start.
// - Sample window 5.12 ms every 0.33 s.
// - Low-energy flag throughout primary, back on ready.
// - Shutdown recovers to normal or drops to sleep.
// - Overvoltage keeps boost off until normal resumes, regulators available.
`timescale 1ns/1ns
module hpm_sequencer #(
	parameter int GRACE_CYCLES = hpm_pkg::GRACE_CYCLES,
	parameter int MPPT_SAMPLE_CYCLES = hpm_pkg::MPPT_SAMPLE_CYCLES,
	parameter int MPPT_PERIOD_CYCLES = hpm_pkg::MPPT_PERIOD_CYCLES
) (
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire hpm_pkg::hpm_comp_s comparators,
	input wire logic coldStartSourceSelect,
	input wire logic lowRailEnablePin,
	input wire logic highRailEnablePin,
	input wire logic [2:0] profileSelect,
	input wire logic [8:0] highRailLimit,
	output logic ldoReadyFlag,
	output logic lowEnergyFlag,
	output logic mpptBusyFlag,
	output logic sourceIsolationSwitch,
	output logic storageLinkSwitch,
	output logic backupCellSwitch,
	output logic boostEnable,
	output logic buckEnable,
	output logic lowRailOutputEnable,
	output logic highRailOutputEnable,
	output logic [8:0] lowRailLevel,
	output logic [8:0] highRailLevel,
	output logic coldStartFromStorage,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_awaddr,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	output logic [1:0] s_axi_bresp,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	input wire logic [31:0] s_axi_araddr,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp
);
	localparam logic [hpm_pkg::TIMER_W-1:0] GRACE_LAST = hpm_pkg::TIMER_W'(GRACE_CYCLES - 1);
	localparam logic [hpm_pkg::TIMER_W-1:0] PERIOD_LAST =
		hpm_pkg::TIMER_W'(MPPT_PERIOD_CYCLES - 1);
	localparam logic [hpm_pkg::TIMER_W-1:0] SAMPLE_LEN = hpm_pkg::TIMER_W'(MPPT_SAMPLE_CYCLES);

	hpm_pkg::hpm_state_s s;
	hpm_pkg::hpm_state_s next_s;
	hpm_pkg::hpm_comp_s cs;
	logic coldOk;

	// Regulators may be enabled in these modes
	function automatic logic isAvail(input hpm_pkg::hpm_mode_e m);
		isAvail = (m == hpm_pkg::NORMAL) || (m == hpm_pkg::OVERVOLTAGE) ||
			(m == hpm_pkg::PRIMARY) || (m == hpm_pkg::SHUTDOWN);
	endfunction

	// Input tracking is active in these modes
	function automatic logic isTracking(input hpm_pkg::hpm_mode_e m);
		isTracking = (m == hpm_pkg::NORMAL) || (m == hpm_pkg::SHUTDOWN) ||
			(m == hpm_pkg::WAKE_CHARGE);
	endfunction

	// Register read decode
	function automatic logic [31:0] regRead(input hpm_pkg::hpm_state_s st, input logic [7:0] a);
		logic [31:0] d;
		d = 32'h0000_0000;
		if (a == hpm_pkg::CTRL_OFFSET)
			d[hpm_pkg::CTRL_CUSTOM_HV_LSB +: 9] = st.customHighRail;
		else if (a == hpm_pkg::STATUS_OFFSET)
		begin
			d[hpm_pkg::STATUS_MODE_LSB +: 3] = st.mode;
			d[hpm_pkg::STATUS_LDO_READY_BIT] = st.ldoReady;
			d[hpm_pkg::STATUS_LOW_ENERGY_BIT] = st.lowEnergy;
			d[hpm_pkg::STATUS_MPPT_BUSY_BIT] = st.mpptBusy;
			d[hpm_pkg::STATUS_COLD_STORAGE_BIT] = st.coldFromStorage;
		end
		regRead = d;
	endfunction

	// Comparator levels into the clock domain
	hpm_sync #(
		.WIDTH($bits(hpm_pkg::hpm_comp_s))
	) u_sync (
		.ref_clk(ref_clk),
		.reset_n(reset_n),
		.asyncIn(comparators),
		.syncOut(cs)
	);

	// Cold-start qualifier picked by the strap
	assign coldOk = s.coldFromStorage ? cs.storageColdOk : cs.sourceColdOk;

	// Mode sequencing, timers, switch and rail control, bus slave
	always_comb
	begin
		next_s = s;
		// Strap caught once after reset release
		if (!s.strapTaken)
		begin
			next_s.strapTaken = 1'b1;
			next_s.coldFromStorage = coldStartSourceSelect;
		end
		unique case (s.mode)
			hpm_pkg::DEEP_SLEEP:
				if (s.strapTaken && coldOk)
					next_s.mode = hpm_pkg::WAKE_RISE;
			hpm_pkg::WAKE_RISE:
				if (cs.boostAtBuckLevel)
					next_s.mode = hpm_pkg::WAKE_BOOST;
			hpm_pkg::WAKE_BOOST:
				if (cs.boostAtFullCharge)
					next_s.mode = cs.storageAboveChargeReady ?
						hpm_pkg::NORMAL : hpm_pkg::WAKE_CHARGE;
			hpm_pkg::WAKE_CHARGE:
				if (cs.storageAboveChargeReady)
					next_s.mode = hpm_pkg::NORMAL;
			hpm_pkg::NORMAL:
				if (cs.storageBelowDepletion)
					next_s.mode = cs.backupCellCharged ?
						hpm_pkg::PRIMARY : hpm_pkg::SHUTDOWN;
				else if (cs.storageAboveFullCharge)
					next_s.mode = hpm_pkg::OVERVOLTAGE;
			hpm_pkg::OVERVOLTAGE:
				if (!cs.storageAboveFullCharge)
					next_s.mode = hpm_pkg::NORMAL;
			hpm_pkg::PRIMARY:
				if (cs.storageAboveChargeReady)
					next_s.mode = hpm_pkg::NORMAL;
			hpm_pkg::SHUTDOWN:
				if (cs.storageAboveChargeReady)
					next_s.mode = hpm_pkg::NORMAL;
				else if (s.graceCount == GRACE_LAST)
					next_s.mode = hpm_pkg::DEEP_SLEEP;
		endcase
		// Grace timer counts cycles spent in shutdown
		next_s.graceCount = (s.mode == hpm_pkg::SHUTDOWN) ?
			s.graceCount + 1'b1 : '0;
		// Tracking period: sample window opens each period
		if (isTracking(s.mode) && s.periodCount != PERIOD_LAST)
			next_s.periodCount = s.periodCount + 1'b1;
		else
			next_s.periodCount = '0;
		next_s.mpptBusy = isTracking(next_s.mode) && (next_s.periodCount < SAMPLE_LEN);
		// Status flags
		next_s.ldoReady = isAvail(next_s.mode);
		next_s.lowEnergy = (next_s.mode == hpm_pkg::PRIMARY) ||
			(next_s.mode == hpm_pkg::SHUTDOWN);
		// Converters: boost held off throughout overvoltage, on again once back in normal
		next_s.buckEnable = (next_s.mode != hpm_pkg::DEEP_SLEEP);
		next_s.boostEnable = (next_s.mode != hpm_pkg::DEEP_SLEEP) &&
			!((next_s.mode == hpm_pkg::OVERVOLTAGE) && cs.storageAboveFullCharge);
		// Switches, high means closed
		next_s.sourceSwitch = !(next_s.mpptBusy || (next_s.mode == hpm_pkg::PRIMARY) ||
			((next_s.mode == hpm_pkg::OVERVOLTAGE) && !next_s.boostEnable));
		next_s.linkSwitch = (next_s.mode == hpm_pkg::NORMAL) ||
			(next_s.mode == hpm_pkg::OVERVOLTAGE) || (next_s.mode == hpm_pkg::WAKE_CHARGE) ||
			(next_s.mode == hpm_pkg::PRIMARY);
		next_s.backupSwitch = (next_s.mode == hpm_pkg::PRIMARY);
		// Effective regulator enables
		next_s.lowRailOn = lowRailEnablePin && isAvail(next_s.mode);
		next_s.highRailOn = highRailEnablePin && isAvail(next_s.mode);
		// Rail levels from the profile
		next_s.lowRailLevel = (profileSelect == 3'h4) ? hpm_pkg::LEVEL_1V2 :
			hpm_pkg::LEVEL_1V8;
		unique case (profileSelect)
			3'h0:
				next_s.highRailLevel = (s.customHighRail > highRailLimit) ?
					highRailLimit : s.customHighRail;
			3'h4:
				next_s.highRailLevel = hpm_pkg::LEVEL_1V8;
			3'h1, 3'h3, 3'h5:
				next_s.highRailLevel = hpm_pkg::LEVEL_2V5;
			default:
				next_s.highRailLevel = hpm_pkg::LEVEL_3V3;
		endcase
		// Write channels, taken in either order
		if (s_axi_awvalid && s_axi_awready)
		begin
			next_s.awHeld = 1'b1;
			next_s.awAddr = s_axi_awaddr[7:0];
		end
		if (s_axi_wvalid && s_axi_wready)
		begin
			next_s.wHeld = 1'b1;
			next_s.wData = s_axi_wdata;
			next_s.wStrb = s_axi_wstrb;
		end
		if (s.awHeld && s.wHeld && !s.bvalid)
		begin
			next_s.awHeld = 1'b0;
			next_s.wHeld = 1'b0;
			next_s.bvalid = 1'b1;
			next_s.bresp = hpm_pkg::RESP_OKAY;
			if (s.awAddr == hpm_pkg::CTRL_OFFSET)
			begin
				if (s.wStrb[0])
					next_s.customHighRail[7:0] = s.wData[7:0];
				if (s.wStrb[1])
					next_s.customHighRail[8] = s.wData[8];
			end
			else if (s.awAddr != hpm_pkg::STATUS_OFFSET)
				next_s.bresp = hpm_pkg::RESP_DECERR;
		end
		else if (s.bvalid && s_axi_bready)
			next_s.bvalid = 1'b0;
		// Read channel
		if (s_axi_arvalid && s_axi_arready)
		begin
			next_s.rvalid = 1'b1;
			next_s.rdata = regRead(s, s_axi_araddr[7:0]);
			next_s.rresp = ((s_axi_araddr[7:0] == hpm_pkg::CTRL_OFFSET) ||
				(s_axi_araddr[7:0] == hpm_pkg::STATUS_OFFSET)) ?
				hpm_pkg::RESP_OKAY : hpm_pkg::RESP_DECERR;
		end
		else if (s.rvalid && s_axi_rready)
			next_s.rvalid = 1'b0;
	end

	// State register
	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			s <= '0;
			s.mode <= hpm_pkg::DEEP_SLEEP;
			s.sourceSwitch <= 1'b1;
			s.lowRailLevel <= hpm_pkg::LEVEL_1V8;
			s.highRailLevel <= hpm_pkg::LEVEL_3V3;
			s.customHighRail <= hpm_pkg::CTRL_CUSTOM_HV_RESET;
		end
		else
			s <= next_s;
	end

	// Outputs
	assign ldoReadyFlag = s.ldoReady;
	assign lowEnergyFlag = s.lowEnergy;
	assign mpptBusyFlag = s.mpptBusy;
	assign sourceIsolationSwitch = s.sourceSwitch;
	assign storageLinkSwitch = s.linkSwitch;
	assign backupCellSwitch = s.backupSwitch;
	assign boostEnable = s.boostEnable;
	assign buckEnable = s.buckEnable;
	assign lowRailOutputEnable = s.lowRailOn;
	assign highRailOutputEnable = s.highRailOn;
	assign lowRailLevel = s.lowRailLevel;
	assign highRailLevel = s.highRailLevel;
	assign coldStartFromStorage = s.coldFromStorage;
	assign s_axi_awready = !s.awHeld && !s.bvalid;
	assign s_axi_wready = !s.wHeld && !s.bvalid;
	assign s_axi_bvalid = s.bvalid;
	assign s_axi_bresp = s.bresp;
	assign s_axi_arready = !s.rvalid;
	assign s_axi_rvalid = s.rvalid;
	assign s_axi_rdata = s.rdata;
	assign s_axi_rresp = s.rresp;

	// Checks on the sequencer
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!reset_n);

	sequence s_wake_charge_ready;
		(s.mode == hpm_pkg::WAKE_CHARGE) && cs.storageAboveChargeReady;
	endsequence
	sequence s_normal_ready;
		(s.mode == hpm_pkg::NORMAL) && ldoReadyFlag && storageLinkSwitch;
	endsequence

	property p_deep_exit;
		(s.mode == hpm_pkg::DEEP_SLEEP) && s.strapTaken && coldOk |=> s.mode == hpm_pkg::WAKE_RISE;
	endproperty
	a_deep_exit: assert property (p_deep_exit) else $error("deep sleep did not wake");
	property p_wake_off;
		(s.mode inside {hpm_pkg::WAKE_RISE, hpm_pkg::WAKE_BOOST, hpm_pkg::WAKE_CHARGE}) |->
			!ldoReadyFlag && !lowRailOutputEnable && !highRailOutputEnable;
	endproperty
	a_wake_off: assert property (p_wake_off) else $error("regulator on in wake up");
	property p_rise_order;
		(s.mode == hpm_pkg::WAKE_RISE) |=> s.mode inside {hpm_pkg::WAKE_RISE, hpm_pkg::WAKE_BOOST};
	endproperty
	a_rise_order: assert property (p_rise_order) else $error("wake rise skipped");
	property p_charge_ready;
		s_wake_charge_ready |=> s_normal_ready;
	endproperty
	a_charge_ready: assert property (p_charge_ready) else $error("no normal at ready");
	property p_direct_normal;
		(s.mode == hpm_pkg::WAKE_BOOST) && cs.boostAtFullCharge && cs.storageAboveChargeReady
			|=> s_normal_ready;
	endproperty
	a_direct_normal: assert property (p_direct_normal) else $error("no direct normal");
	property p_normal_hold;
		(s.mode == hpm_pkg::NORMAL) && !cs.storageBelowDepletion && !cs.storageAboveFullCharge
			|=> s.mode == hpm_pkg::NORMAL;
	endproperty
	a_normal_hold: assert property (p_normal_hold) else $error("normal left early");
	property p_overvoltage;
		(s.mode == hpm_pkg::NORMAL) && !cs.storageBelowDepletion && cs.storageAboveFullCharge
			|=> s.mode == hpm_pkg::OVERVOLTAGE;
	endproperty
	a_overvoltage: assert property (p_overvoltage) else $error("no overvoltage");
	property p_depletion;
		(s.mode == hpm_pkg::NORMAL) && cs.storageBelowDepletion |=>
			s.mode == ($past(cs.backupCellCharged) ? hpm_pkg::PRIMARY : hpm_pkg::SHUTDOWN)
			&& lowEnergyFlag && (storageLinkSwitch == backupCellSwitch);
	endproperty
	a_depletion: assert property (p_depletion) else $error("bad depletion exit");
	property p_primary_sw;
		(s.mode == hpm_pkg::PRIMARY) |-> backupCellSwitch && !sourceIsolationSwitch && lowEnergyFlag;
	endproperty
	a_primary_sw: assert property (p_primary_sw) else $error("primary switches wrong");
	property p_rail_follow;
		isAvail(s.mode) ##1 isAvail(s.mode) |->
			lowRailOutputEnable == $past(lowRailEnablePin) &&
			highRailOutputEnable == $past(highRailEnablePin);
	endproperty
	a_rail_follow: assert property (p_rail_follow) else $error("rail ignores pin");
	property p_grace;
		($past(s.mode) == hpm_pkg::SHUTDOWN) && (s.mode == hpm_pkg::DEEP_SLEEP) |->
			$past(s.graceCount) == GRACE_LAST;
	endproperty
	a_grace: assert property (p_grace) else $error("shutdown before grace time");
	property p_sample;
		mpptBusyFlag |-> !sourceIsolationSwitch && (s.periodCount < SAMPLE_LEN);
	endproperty
	a_sample: assert property (p_sample) else $error("sample window wrong");
	property p_ov_boost;
		(s.mode == hpm_pkg::OVERVOLTAGE) |=>
			(boostEnable == !$past(cs.storageAboveFullCharge)) && ldoReadyFlag;
	endproperty
	a_ov_boost: assert property (p_ov_boost) else $error("boost idle below full");
endmodule

/* File: bench/hpm_load_model.sv */
// Load controller model standing on the far side of the regulator pins.
// Assumes the sequencer's flags are synchronous to ref_clk.
`timescale 1ns/1ns
module hpm_load_model (
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic ldoReadyFlag,
	input wire logic wantLow,
	input wire logic wantHigh,
	output logic lowRailEnablePin,
	output logic highRailEnablePin
);
	// Enables follow demand, driven dynamically, only while ready is seen
	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			lowRailEnablePin <= 1'b0;
			highRailEnablePin <= 1'b0;
		end
		else
		begin
			lowRailEnablePin <= wantLow & ldoReadyFlag;
			highRailEnablePin <= wantHigh & ldoReadyFlag;
		end
	end
endmodule

/* File: bench/tb_harvester_power_mode_sequencer.sv */
// Self-checking bench of the power mode sequencer.
// Assumes short timer parameters and a load model on the rail pins.
`timescale 1ns/1ns
module tb_harvester_power_mode_sequencer;
	localparam int GRACE = 20;
	localparam int SAMPLE = 4;
	localparam int PERIOD = 16;
	logic ref_clk, reset_n, strap, wantLow, wantHigh, lowPin, highPin;
	hpm_pkg::hpm_comp_s comp;
	logic [2:0] profileSelect;
	logic [8:0] highRailLimit, lowRailLevel, highRailLevel;
	logic ldoReadyFlag, lowEnergyFlag, mpptBusyFlag, srcSw, linkSw, backupSw;
	logic boostEn, buckEn, lowOut, highOut, coldStore;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	int err_total = 0;
	int samples_checked = 0;

	// Design under test with shortened timers
	hpm_sequencer #(.GRACE_CYCLES(GRACE), .MPPT_SAMPLE_CYCLES(SAMPLE),
		.MPPT_PERIOD_CYCLES(PERIOD)) DUT (
		.ref_clk, .reset_n, .comparators(comp), .coldStartSourceSelect(strap),
		.lowRailEnablePin(lowPin), .highRailEnablePin(highPin), .profileSelect,
		.highRailLimit, .ldoReadyFlag, .lowEnergyFlag, .mpptBusyFlag,
		.sourceIsolationSwitch(srcSw), .storageLinkSwitch(linkSw),
		.backupCellSwitch(backupSw), .boostEnable(boostEn), .buckEnable(buckEn),
		.lowRailOutputEnable(lowOut), .highRailOutputEnable(highOut), .lowRailLevel,
		.highRailLevel, .coldStartFromStorage(coldStore), .s_axi_awvalid,
		.s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
		.s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
		.s_axi_rresp);

	// Load controller on the rail pins
	hpm_load_model LOAD (.ref_clk, .reset_n, .ldoReadyFlag, .wantLow, .wantHigh,
		.lowRailEnablePin(lowPin), .highRailEnablePin(highPin));

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			err_total++;
			$display("unexpected %s: expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
	endtask

	// Bus write: address and data offered together, response awaited
	task automatic axiWrite(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
		@(posedge ref_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		forever
		begin
			@(posedge ref_clk);
			if (s_axi_awvalid && s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready)
				s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid)
			begin
				r = s_axi_bresp;
				s_axi_bready <= 1'b0;
				break;
			end
		end
	endtask

	// Bus read: address held until taken, data taken with rvalid
	task automatic axiRead(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge ref_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		forever
		begin
			@(posedge ref_clk);
			if (s_axi_arvalid && s_axi_arready)
				s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid)
			begin
				d = s_axi_rdata;
				r = s_axi_rresp;
				s_axi_rready <= 1'b0;
				break;
			end
		end
	endtask

	// Polls the status register until the mode matches, then compares
	task automatic waitMode(input hpm_pkg::hpm_mode_e m);
		logic [31:0] d;
		logic [1:0] r;
		for (int i = 0; i < 40; i++)
		begin
			axiRead({24'h00, hpm_pkg::STATUS_OFFSET}, d, r);
			if (d[2:0] === m)
				break;
		end
		check("mode", {29'h0, d[2:0]}, {29'h0, m});
	endtask

	task automatic t_wake();
		check("strap", coldStore, 1'b0);
		check("source sw", srcSw, 1'b1);
		comp.sourceColdOk <= 1'b1;
		waitMode(hpm_pkg::WAKE_RISE);
		wantLow <= 1'b1;
		wantHigh <= 1'b1;
		comp.boostAtBuckLevel <= 1'b1;
		waitMode(hpm_pkg::WAKE_BOOST);
		check("wake ready", ldoReadyFlag, 1'b0);
		check("wake rails", {lowOut, highOut}, 2'h0);
		check("wake conv", {boostEn, buckEn}, 2'h3);
		comp.boostAtFullCharge <= 1'b1;
		waitMode(hpm_pkg::WAKE_CHARGE);
		check("charge ready", ldoReadyFlag, 1'b0);
		comp.storageAboveChargeReady <= 1'b1;
		waitMode(hpm_pkg::NORMAL);
		check("normal ready", ldoReadyFlag, 1'b1);
		check("link sw", linkSw, 1'b1);
		$display("test wake done");
	endtask

	task automatic t_rails();
		logic [8:0] hv [8] = '{9'h000, hpm_pkg::LEVEL_2V5, hpm_pkg::LEVEL_3V3,
			hpm_pkg::LEVEL_2V5, hpm_pkg::LEVEL_1V8, hpm_pkg::LEVEL_2V5,
			hpm_pkg::LEVEL_3V3, hpm_pkg::LEVEL_3V3};
		logic [31:0] d;
		logic [1:0] r;
		for (int i = 0; i < 4; i++)
		begin
			wantLow <= i[0];
			wantHigh <= i[1];
			tick(4);
			check("low out", lowOut, i[0]);
			check("high out", highOut, i[1]);
		end
		for (int p = 1; p < 8; p++)
		begin
			profileSelect <= p[2:0];
			tick(3);
			check("hv level", highRailLevel, hv[p]);
			check("lv level", lowRailLevel, p == 4 ? hpm_pkg::LEVEL_1V2 : hpm_pkg::LEVEL_1V8);
		end
		profileSelect <= 3'h0;
		highRailLimit <= 9'h0FA;
		axiWrite({24'h00, hpm_pkg::CTRL_OFFSET}, 32'h000000C8, r);
		check("ctrl resp", r, hpm_pkg::RESP_OKAY);
		axiRead({24'h00, hpm_pkg::CTRL_OFFSET}, d, r);
		check("ctrl back", d[8:0], 9'h0C8);
		tick(3);
		check("custom hv", highRailLevel, 9'h0C8);
		highRailLimit <= 9'h0B4;
		tick(3);
		check("clamped hv", highRailLevel, 9'h0B4);
		$display("test rails done");
	endtask

	task automatic t_bus();
		logic [31:0] d;
		logic [1:0] r;
		axiRead(32'h00000040, d, r);
		check("unmapped resp", r, hpm_pkg::RESP_DECERR);
		check("unmapped data", d, 32'h00000000);
		axiWrite({24'h00, hpm_pkg::STATUS_OFFSET}, 32'h00000000, r);
		check("status wr", r, hpm_pkg::RESP_OKAY);
		axiRead({24'h00, hpm_pkg::STATUS_OFFSET}, d, r);
		check("status ready", d[3], 1'b1);
		$display("test bus done");
	endtask

	task automatic t_over();
		comp.storageAboveFullCharge <= 1'b1;
		waitMode(hpm_pkg::OVERVOLTAGE);
		check("ov rails", {lowOut, highOut}, 2'h3);
		check("ov boost", boostEn, 1'b0);
		comp.storageAboveFullCharge <= 1'b0;
		waitMode(hpm_pkg::NORMAL);
		check("ov boost on", boostEn, 1'b1);
		tick(40);
		waitMode(hpm_pkg::NORMAL);
		$display("test overvoltage done");
	endtask

	task automatic t_mppt();
		int n = 0;
		int m = 0;
		// Start from the idle part so that a whole window is counted
		while (mpptBusyFlag === 1'b1 && m < 100)
		begin
			m++;
			tick(1);
		end
		m = 0;
		for (int i = 0; i < 2 * PERIOD && !mpptBusyFlag; i++)
			tick(1);
		check("sample sw", srcSw, 1'b0);
		while (mpptBusyFlag === 1'b1 && n < 100)
		begin
			n++;
			tick(1);
		end
		while (mpptBusyFlag === 1'b0 && m < 100)
		begin
			m++;
			tick(1);
		end
		check("sample len", n, SAMPLE);
		check("period len", n + m, PERIOD);
		$display("test tracking done");
	endtask

	task automatic t_primary();
		comp.storageAboveChargeReady <= 1'b0;
		comp.backupCellCharged <= 1'b1;
		comp.storageBelowDepletion <= 1'b1;
		waitMode(hpm_pkg::PRIMARY);
		check("prim sw", {backupSw, srcSw}, 2'h2);
		tick(30);
		check("prim flag", lowEnergyFlag, 1'b1);
		comp.storageBelowDepletion <= 1'b0;
		comp.storageAboveChargeReady <= 1'b1;
		waitMode(hpm_pkg::NORMAL);
		check("prim off", {lowEnergyFlag, backupSw}, 2'h0);
		$display("test primary done");
	endtask

	task automatic t_shutdown();
		int n = 0;
		comp.backupCellCharged <= 1'b0;
		// No cold-start source, so deep sleep is kept once reached
		comp.sourceColdOk <= 1'b0;
		comp.storageAboveChargeReady <= 1'b0;
		comp.storageBelowDepletion <= 1'b1;
		waitMode(hpm_pkg::SHUTDOWN);
		check("sd link", linkSw, 1'b0);
		check("sd flag", lowEnergyFlag, 1'b1);
		comp.storageBelowDepletion <= 1'b0;
		comp.storageAboveChargeReady <= 1'b1;
		waitMode(hpm_pkg::NORMAL);
		comp.storageAboveChargeReady <= 1'b0;
		comp.storageBelowDepletion <= 1'b1;
		for (int i = 0; i < 50 && !lowEnergyFlag; i++)
			tick(1);
		while (ldoReadyFlag === 1'b1 && n < 1000)
		begin
			n++;
			tick(1);
		end
		check("grace", n >= GRACE - 1 && n <= GRACE + 2, 1'b1);
		waitMode(hpm_pkg::DEEP_SLEEP);
		check("sleep outs", {lowOut, highOut, linkSw, boostEn, buckEn}, 5'h00);
		$display("test shutdown done");
	endtask

	task automatic t_strap();
		comp <= '0;
		strap <= 1'b1;
		reset_n <= 1'b0;
		tick(8);
		reset_n <= 1'b1;
		tick(3);
		check("strap", coldStore, 1'b1);
		comp.storageColdOk <= 1'b1;
		waitMode(hpm_pkg::WAKE_RISE);
		comp.boostAtBuckLevel <= 1'b1;
		comp.boostAtFullCharge <= 1'b1;
		comp.storageAboveChargeReady <= 1'b1;
		waitMode(hpm_pkg::NORMAL);
		check("direct ready", ldoReadyFlag, 1'b1);
		$display("test strap done");
	endtask

	// Free-running bench clock
	initial
	begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end

	// Hang guard
	initial
	begin
		#300000;
		err_total++;
		end_of_test();
	end

	// Main sequence
	initial
	begin
		reset_n = 1'b0;
		comp = '0;
		strap = 1'b0;
		wantLow = 1'b0;
		wantHigh = 1'b0;
		profileSelect = 3'h7;
		highRailLimit = 9'h14A;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
		s_axi_awaddr = 32'h00000000;
		s_axi_araddr = 32'h00000000;
		s_axi_wdata = 32'h00000000;
		s_axi_wstrb = 4'hF;
		tick(8);
		reset_n <= 1'b1;
		tick(2);
		t_wake();
		t_rails();
		t_bus();
		t_over();
		t_mppt();
		t_primary();
		t_shutdown();
		t_strap();
		end_of_test();
	end
endmodule
